// ---- design/eas_entry_io.sv ----
// entry assembly parser, configuration assembly and switching io object
`timescale 1ns/1ns
module eas_entry_io import eas_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic asm_valid,
  input wire logic [7:0] asm_data,
  input wire logic asm_last,
  output logic asm_ready,
  output logic [7:0] frag_num,
  output logic [7:0] frag_rem,
  output logic [7:0] frag_size,
  output logic new_entry,
  output logic new_data,
  output logic [15:0] entry_len,
  output logic asm_len_err,
  output logic pay_valid,
  output logic [7:0] pay_data,
  input wire logic pay_ready,
  input wire logic conn_setup,
  input wire logic cfg_valid,
  input wire logic [7:0] cfg_data,
  input wire logic cfg_last,
  output logic hs_mode,
  output logic res_frag_en,
  output logic ent_frag_en,
  output logic cfg_err,
  input wire logic svc_valid,
  input wire logic [7:0] svc_code,
  input wire logic [7:0] svc_class,
  input wire logic [7:0] svc_inst,
  input wire logic [7:0] svc_attr,
  input wire logic [7:0] svc_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_err,
  input wire logic [1:0] sw_in,
  input wire logic [1:0] evt,
  input wire logic [15:0] cmp_limit,
  input wire logic multi_switch,
  output logic [1:0] sw_out
);
  function automatic logic attr_get_ok(input logic [7:0] code, input logic [7:0] attr);
    attr_get_ok = (code == SVC_GET_SINGLE) &&
      (attr == ATTR_STATUS || attr == ATTR_CMP_STATE || attr == ATTR_CMP_TOGGLE);
  endfunction : attr_get_ok

  function automatic logic attr_set_ok(input logic [7:0] code, input logic [7:0] attr,
                                       input logic [7:0] wdata);
    attr_set_ok = (code == SVC_SET_SINGLE) && (wdata <= ATTR_MAX_VALUE) &&
      (attr == ATTR_DRIVE || attr == ATTR_EV_RESET);
  endfunction : attr_set_ok

  eas_asm_state_t st_ff, nxt_st;
  logic [8:0] idx_ff, nxt_idx;
  logic [7:0] frag_num_ff, nxt_frag_num, frag_rem_ff, nxt_frag_rem, frag_size_ff, nxt_frag_size;
  logic [15:0] entry_len_ff, nxt_entry_len;
  logic new_entry_ff, nxt_new_entry, new_data_ff, nxt_new_data;
  logic tog_prev_ff, nxt_tog_prev, len_err_ff, nxt_len_err;
  logic acc, fifo_in_valid, fifo_in_ready;

  assign asm_ready = fifo_in_ready;
  assign frag_num = frag_num_ff;
  assign frag_rem = frag_rem_ff;
  assign frag_size = frag_size_ff;
  assign entry_len = entry_len_ff;
  assign new_entry = new_entry_ff;
  assign new_data = new_data_ff;
  assign asm_len_err = len_err_ff;

  // header bytes also wait on buffer room, keeps the parser single-ready
  always_comb begin
    acc = asm_valid && fifo_in_ready;
    fifo_in_valid = asm_valid && (st_ff == EAS_ASM_PAY);
    nxt_st = st_ff;
    nxt_idx = idx_ff;
    nxt_frag_num = frag_num_ff;
    nxt_frag_rem = frag_rem_ff;
    nxt_frag_size = frag_size_ff;
    nxt_entry_len = entry_len_ff;
    nxt_new_entry = 1'b0;
    nxt_new_data = new_data_ff;
    nxt_tog_prev = tog_prev_ff;
    nxt_len_err = len_err_ff;
    if (acc) begin
      nxt_idx = (idx_ff == ASM_IDX_SAT) ? idx_ff : idx_ff + 9'h001;
      if (idx_ff == ASM_FRAG_NUM_IDX) begin
        nxt_len_err = 1'b0;
      end
      unique case (st_ff)
        EAS_ASM_HDR: begin
          unique case (idx_ff)
            ASM_FRAG_NUM_IDX: nxt_frag_num = asm_data;
            ASM_FRAG_REM_IDX: nxt_frag_rem = asm_data;
            ASM_FRAG_SIZE_IDX: nxt_frag_size = asm_data;
            ASM_FLAGS_IDX: begin
              // only a change of the entry bit announces a new entry
              nxt_new_entry = asm_data[ASM_NEW_ENTRY_BIT] ^ tog_prev_ff;
              nxt_tog_prev = asm_data[ASM_NEW_ENTRY_BIT];
              nxt_new_data = asm_data[ASM_NEW_DATA_BIT];
            end
            ASM_LEN_LO_IDX: nxt_entry_len = {entry_len_ff[15:8], asm_data};
            ASM_LEN_HI_IDX: begin
              nxt_entry_len = {asm_data, entry_len_ff[7:0]};
              nxt_st = EAS_ASM_PAY;
            end
            default: nxt_st = EAS_ASM_HDR;
          endcase
        end
        EAS_ASM_PAY: begin
          if (idx_ff == ASM_PAY_LAST_IDX) begin
            nxt_st = EAS_ASM_OVF;
          end
        end
        EAS_ASM_OVF: nxt_len_err = 1'b1;
        default: nxt_st = EAS_ASM_HDR;
      endcase
      if (asm_last) begin
        nxt_idx = ASM_FRAG_NUM_IDX;
        nxt_st = EAS_ASM_HDR;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff <= EAS_ASM_HDR;
      idx_ff <= ASM_FRAG_NUM_IDX;
      frag_num_ff <= 8'h00;
      frag_rem_ff <= 8'h00;
      frag_size_ff <= 8'h00;
      entry_len_ff <= 16'h0000;
      new_entry_ff <= 1'b0;
      new_data_ff <= 1'b0;
      tog_prev_ff <= 1'b0;
      len_err_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      idx_ff <= nxt_idx;
      frag_num_ff <= nxt_frag_num;
      frag_rem_ff <= nxt_frag_rem;
      frag_size_ff <= nxt_frag_size;
      entry_len_ff <= nxt_entry_len;
      new_entry_ff <= nxt_new_entry;
      new_data_ff <= nxt_new_data;
      tog_prev_ff <= nxt_tog_prev;
      len_err_ff <= nxt_len_err;
    end
  end

  eas_fifo #(.WIDTH(PAY_FIFO_WIDTH), .DEPTH(PAY_FIFO_DEPTH)) u_pay_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_data(asm_data),
    .in_ready(fifo_in_ready),
    .out_valid(pay_valid),
    .out_data(pay_data),
    .out_ready(pay_ready)
  );

  // configuration assembly, committed only when exactly three bytes arrive
  logic [1:0] cfg_idx_ff, nxt_cfg_idx;
  logic [1:0] cfg_shadow_ff, nxt_cfg_shadow;
  logic [2:0] cfg_ff, nxt_cfg;
  logic cfg_err_ff, nxt_cfg_err, cfg_commit;

  assign hs_mode = cfg_ff[CFG_HS_MODE_OFS];
  assign res_frag_en = cfg_ff[CFG_RES_FRAG_OFS];
  assign ent_frag_en = cfg_ff[CFG_ENT_FRAG_OFS];
  assign cfg_err = cfg_err_ff;

  always_comb begin
    nxt_cfg_idx = cfg_idx_ff;
    nxt_cfg_shadow = cfg_shadow_ff;
    nxt_cfg = cfg_ff;
    nxt_cfg_err = cfg_err_ff;
    cfg_commit = cfg_valid && conn_setup && cfg_last && (cfg_idx_ff == CFG_ENT_FRAG_OFS);
    if (cfg_valid && !conn_setup) begin
      nxt_cfg_err = 1'b1;
    end else if (cfg_valid) begin
      if (cfg_idx_ff == CFG_HS_MODE_OFS) begin
        nxt_cfg_err = 1'b0;
      end
      if (cfg_idx_ff != CFG_IDX_OVF) begin
        nxt_cfg_idx = cfg_idx_ff + 2'h1;
      end
      if (cfg_idx_ff == CFG_HS_MODE_OFS || cfg_idx_ff == CFG_RES_FRAG_OFS) begin
        nxt_cfg_shadow[cfg_idx_ff[0]] = cfg_data[CFG_ENABLE_BIT];
      end
      if (cfg_last) begin
        nxt_cfg_idx = CFG_HS_MODE_OFS;
        if (cfg_commit) begin
          // reserved bits are dropped, only bit 0 of each byte is kept
          nxt_cfg = {cfg_data[CFG_ENABLE_BIT], cfg_shadow_ff};
        end else begin
          nxt_cfg_err = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_idx_ff <= CFG_HS_MODE_OFS;
      cfg_shadow_ff <= 2'h0;
      cfg_ff <= {CFG_RST[CFG_ENABLE_BIT], CFG_RST[CFG_ENABLE_BIT], CFG_RST[CFG_ENABLE_BIT]};
      cfg_err_ff <= 1'b0;
    end else begin
      cfg_idx_ff <= nxt_cfg_idx;
      cfg_shadow_ff <= nxt_cfg_shadow;
      cfg_ff <= nxt_cfg;
      cfg_err_ff <= nxt_cfg_err;
    end
  end

  // switching io object, two channels
  logic [1:0] sw_state_ff, sw_out_ff, nxt_sw_out, evrst_ff, nxt_evrst, cmp_ff, nxt_cmp, tog_ff, nxt_tog;
  logic [1:0][15:0] ev_cnt_ff, nxt_ev_cnt;
  logic rsp_valid_ff, rsp_err_ff, nxt_rsp_err, svc_ok, svc_ch;
  logic [7:0] rsp_data_ff, nxt_rsp_data;
  logic [1:0] clr;
  logic [15:0] cnt_base, cnt_inc;

  assign sw_out = sw_out_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_data = rsp_data_ff;
  assign rsp_err = rsp_err_ff;

  always_comb begin
    svc_ch = (svc_inst == SWIO_INST_2);
    svc_ok = svc_valid && (svc_class == SWIO_CLASS) &&
      (svc_inst == SWIO_INST_1 || svc_inst == SWIO_INST_2) &&
      (attr_get_ok(svc_code, svc_attr) || attr_set_ok(svc_code, svc_attr, svc_wdata));
    nxt_rsp_err = svc_valid && !svc_ok;
    nxt_rsp_data = 8'h00;
    if (svc_ok && svc_code == SVC_GET_SINGLE) begin
      unique case (svc_attr)
        ATTR_STATUS: nxt_rsp_data = {7'h00, sw_state_ff[svc_ch]};
        ATTR_CMP_STATE: nxt_rsp_data = {7'h00, cmp_ff[svc_ch]};
        default: nxt_rsp_data = {7'h00, tog_ff[svc_ch]};
      endcase
    end
    nxt_sw_out = sw_out_ff;
    nxt_evrst = evrst_ff;
    clr = 2'b00;
    if (svc_ok && svc_code == SVC_SET_SINGLE) begin
      if (svc_attr == ATTR_DRIVE) begin
        nxt_sw_out[svc_ch] = svc_wdata[0];
      end else begin
        nxt_evrst[svc_ch] = svc_wdata[0];
        clr[svc_ch] = svc_wdata[0] && !evrst_ff[svc_ch];
      end
    end
    nxt_ev_cnt = ev_cnt_ff;
    nxt_cmp = cmp_ff;
    nxt_tog = tog_ff;
    cnt_base = EV_CNT_RST;
    cnt_inc = EV_CNT_RST;
    for (int i = 0; i < 2; i++) begin
      // an event in the clearing cycle still counts
      cnt_base = clr[i] ? EV_CNT_RST : ev_cnt_ff[i];
      nxt_ev_cnt[i] = cnt_base;
      nxt_cmp[i] = cmp_ff[i] && !clr[i];
      nxt_tog[i] = tog_ff[i] && !clr[i];
      cnt_inc = cnt_base + 16'h0001;
      if (evt[i] && cnt_inc != EV_CNT_RST) begin
        nxt_ev_cnt[i] = cnt_inc;
        if (cnt_inc > cmp_limit) begin
          nxt_cmp[i] = 1'b1;
          if (multi_switch) begin
            nxt_tog[i] = !nxt_tog[i];
            nxt_ev_cnt[i] = EV_CNT_RST;
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sw_state_ff <= 2'b00;
      sw_out_ff <= 2'b00;
      evrst_ff <= 2'b00;
      cmp_ff <= 2'b00;
      tog_ff <= 2'b00;
      ev_cnt_ff <= '0;
      rsp_valid_ff <= 1'b0;
      rsp_err_ff <= 1'b0;
      rsp_data_ff <= 8'h00;
    end else begin
      sw_state_ff <= sw_in;
      sw_out_ff <= nxt_sw_out;
      evrst_ff <= nxt_evrst;
      cmp_ff <= nxt_cmp;
      tog_ff <= nxt_tog;
      ev_cnt_ff <= nxt_ev_cnt;
      rsp_valid_ff <= svc_valid;
      rsp_err_ff <= nxt_rsp_err;
      rsp_data_ff <= nxt_rsp_data;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  frag_hdr_a: assert property (acc && st_ff == EAS_ASM_HDR && idx_ff == ASM_FRAG_NUM_IDX |=>
    frag_num == $past(asm_data)) else $error("fragment number not taken from byte 0");
  len_order_a: assert property (acc && st_ff == EAS_ASM_HDR && idx_ff == ASM_LEN_HI_IDX |=>
    entry_len[15:8] == $past(asm_data) && $stable(entry_len[7:0])) else $error("length high byte misplaced");
  pay_start_a: assert property (fifo_in_valid && fifo_in_ready |->
    idx_ff >= ASM_PAY_FIRST_IDX && idx_ff <= ASM_PAY_LAST_IDX) else $error("payload pushed out of range");
  len_max_a: assert property (acc && st_ff == EAS_ASM_OVF |=> asm_len_err)
    else $error("overlong assembly not flagged");
  cfg_apply_a: assert property (cfg_commit |=> ent_frag_en == $past(cfg_data[0]) && !cfg_err)
    else $error("configuration not applied");
  cfg_hold_a: assert property (!cfg_commit |=> $stable(hs_mode) && $stable(res_frag_en))
    else $error("configuration changed without commit");
  svc_class_a: assert property (svc_valid && svc_class != SWIO_CLASS |=> rsp_valid && rsp_err)
    else $error("foreign class not refused");
  attr_res_a: assert property (svc_valid && svc_attr < ATTR_STATUS |=> rsp_err)
    else $error("reserved attribute accepted");
  drive_a: assert property (svc_ok && svc_code == SVC_SET_SINGLE && svc_attr == ATTR_DRIVE && !svc_ch |=>
    sw_out[0] == $past(svc_wdata[0])) else $error("output drive not applied");
  edge_clr_a: assert property (clr[0] |=> ev_cnt_ff[0] <= 16'h0001)
    else $error("event counter not cleared");
  tog_lvl_a: assert property (acc && st_ff == EAS_ASM_HDR && idx_ff == ASM_FLAGS_IDX &&
    asm_data[ASM_NEW_ENTRY_BIT] == tog_prev_ff |=> !new_entry) else $error("new entry on a level");
  cmp_rise_a: assert property ($rose(cmp_ff[0]) |-> $past(evt[0]))
    else $error("comparison state set without event");

  new_entry_c: cover property (new_entry);
  cmp_rise_c: cover property ($rose(cmp_ff[1]) ##[1:20] clr[1]);
  cfg_commit_c: cover property (cfg_commit);
  fifo_full_c: cover property (asm_valid && !asm_ready);
endmodule : eas_entry_io

// ---- design/eas_pkg.sv ----
// constants and types shared by the entry assembly and switching io logic
package eas_pkg;
  // entry assembly byte positions
  localparam logic [8:0] ASM_FRAG_NUM_IDX = 9'h000;
  localparam logic [8:0] ASM_FRAG_REM_IDX = 9'h001;
  localparam logic [8:0] ASM_FRAG_SIZE_IDX = 9'h002;
  localparam logic [8:0] ASM_FLAGS_IDX = 9'h003;
  localparam logic [8:0] ASM_LEN_LO_IDX = 9'h004;
  localparam logic [8:0] ASM_LEN_HI_IDX = 9'h005;
  localparam logic [8:0] ASM_PAY_FIRST_IDX = 9'h006;
  localparam logic [8:0] ASM_PAY_LAST_IDX = 9'h104;
  localparam logic [8:0] ASM_MAX_LEN = 9'h105;
  localparam logic [8:0] ASM_IDX_SAT = 9'h1ff;
  localparam int ASM_NEW_ENTRY_BIT = 4;
  localparam int ASM_NEW_DATA_BIT = 3;
  // configuration assembly
  localparam logic [1:0] CFG_HS_MODE_OFS = 2'h0;
  localparam logic [1:0] CFG_RES_FRAG_OFS = 2'h1;
  localparam logic [1:0] CFG_ENT_FRAG_OFS = 2'h2;
  localparam logic [1:0] CFG_IDX_OVF = 2'h3;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam int CFG_ENABLE_BIT = 0;
  // switching io object
  localparam logic [7:0] SWIO_CLASS = 8'h67;
  localparam logic [7:0] SVC_GET_SINGLE = 8'h0e;
  localparam logic [7:0] SVC_SET_SINGLE = 8'h10;
  localparam logic [7:0] SWIO_INST_1 = 8'h01;
  localparam logic [7:0] SWIO_INST_2 = 8'h02;
  localparam logic [7:0] ATTR_STATUS = 8'h05;
  localparam logic [7:0] ATTR_DRIVE = 8'h06;
  localparam logic [7:0] ATTR_EV_RESET = 8'h07;
  localparam logic [7:0] ATTR_CMP_STATE = 8'h08;
  localparam logic [7:0] ATTR_CMP_TOGGLE = 8'h09;
  localparam logic [7:0] ATTR_MAX_VALUE = 8'h01;
  localparam logic [15:0] EV_CNT_RST = 16'h0000;
  // payload buffer
  localparam int PAY_FIFO_WIDTH = 8;
  localparam int PAY_FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    EAS_ASM_HDR = 2'b00,
    EAS_ASM_PAY = 2'b01,
    EAS_ASM_OVF = 2'b10
  } eas_asm_state_t;
endpackage : eas_pkg

// ---- design/eas_fifo.sv ----
// payload buffer with valid and ready on both sides
`timescale 1ns/1ns
module eas_fifo import eas_pkg::*; #(
  parameter int WIDTH = PAY_FIFO_WIDTH,
  parameter int DEPTH = PAY_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr;
  logic [AW-1:0] rd_ptr_ff, nxt_rd_ptr;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic push, pop;
  // ready and valid held in flops so the top outputs carry no decode
  logic in_ready_ff, nxt_in_ready, out_valid_ff, nxt_out_valid;

  assign in_ready = in_ready_ff;
  assign out_valid = out_valid_ff;
  assign out_data = mem_ff[rd_ptr_ff];

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
    nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
    nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    nxt_in_ready = (nxt_cnt != DEPTH[AW:0]);
    nxt_out_valid = (nxt_cnt != '0);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
      in_ready_ff <= 1'b1;
      out_valid_ff <= 1'b0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      cnt_ff <= nxt_cnt;
      in_ready_ff <= nxt_in_ready;
      out_valid_ff <= nxt_out_valid;
    end
  end

  // storage has no reset, contents are only read behind valid
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end
endmodule : eas_fifo

// ---- dv/eas_ctrl_model.sv ----
// fieldbus controller model driving entry and configuration assemblies
`timescale 1ns/1ns
module eas_ctrl_model (
  input wire logic ref_clk,
  input wire logic asm_ready,
  output logic asm_valid,
  output logic [7:0] asm_data,
  output logic asm_last,
  output logic conn_setup,
  output logic cfg_valid,
  output logic [7:0] cfg_data,
  output logic cfg_last
);
  initial begin
    asm_valid = 1'b0;
    asm_data = 8'h00;
    asm_last = 1'b0;
    conn_setup = 1'b0;
    cfg_valid = 1'b0;
    cfg_data = 8'h00;
    cfg_last = 1'b0;
  end
  // released data shows the inverse so a stale byte never passes for a fresh one
  task automatic send_raw(input logic [7:0] b[$], input int gap, output bit ok);
    int n;
    ok = 1'b1;
    foreach (b[i]) begin
      asm_valid <= 1'b1;
      asm_data <= b[i];
      asm_last <= (i == b.size() - 1);
      n = 0;
      @(posedge ref_clk);
      while (asm_ready !== 1'b1 && n < 2000) begin
        n++;
        @(posedge ref_clk);
      end
      if (n == 2000) ok = 1'b0;
      if (gap > 0 || i == b.size() - 1) begin
        asm_valid <= 1'b0;
        asm_last <= 1'b0;
        asm_data <= ~b[i];
        repeat (gap + (i == b.size() - 1)) @(posedge ref_clk);
      end
    end
  endtask : send_raw
  task automatic send_entry(input logic [7:0] fn, rf, fs, input logic tog, nd,
                            input logic [7:0] pay[$], input int gap, output bit ok);
    logic [7:0] b[$];
    logic [15:0] len;
    len = 16'(pay.size());
    b = '{fn, rf, fs, {3'h0, tog, nd, 3'h0}, len[7:0], len[15:8]};
    b = {b, pay};
    send_raw(b, gap, ok);
  endtask : send_entry
  task automatic send_cfg(input logic [7:0] b[$], input logic setup);
    conn_setup <= setup;
    foreach (b[i]) begin
      cfg_valid <= 1'b1;
      cfg_data <= b[i];
      cfg_last <= (i == b.size() - 1);
      @(posedge ref_clk);
    end
    cfg_valid <= 1'b0;
    cfg_last <= 1'b0;
    cfg_data <= ~cfg_data;
    @(posedge ref_clk);
    conn_setup <= 1'b0;
    @(posedge ref_clk);
  endtask : send_cfg
endmodule : eas_ctrl_model

// ---- dv/entry_assembly_and_switch_io_objects_tb_top.sv ----
// self-checking bench for the entry assembly and switching io block
`timescale 1ns/1ns
module entry_assembly_and_switch_io_objects_tb_top;
  import eas_pkg::*;
  logic ref_clk, rst, asm_valid, asm_last, asm_ready, new_entry, new_data, asm_len_err;
  logic [7:0] asm_data, frag_num, frag_rem, frag_size, pay_data, cfg_data, svc_code, svc_class;
  logic [7:0] svc_inst, svc_attr, svc_wdata, rsp_data, fn, inst, d;
  logic [15:0] entry_len, cmp_limit;
  logic pay_valid, pay_ready, conn_setup, cfg_valid, cfg_last, hs_mode, res_frag_en, ent_frag_en;
  logic cfg_err, svc_valid, rsp_valid, rsp_err, multi_switch, drain_en, tog, nd, prev, v, e;
  logic [1:0] sw_in, evt, sw_out, exp_out;
  logic [7:0] expq[$], pay[$];
  logic [39:0] bad_req [8] = '{40'h660e010500, 40'h670e030500, 40'h6701010500, 40'h670e010400,
                               40'h670e010600, 40'h6710010500, 40'h6710010602, 40'h670e000100};
  int bad_count, checks_done, ne_cnt, ne_before;
  bit ok;

  eas_entry_io u_eas_entry_io (.ref_clk, .rst, .asm_valid, .asm_data, .asm_last, .asm_ready,
    .frag_num, .frag_rem, .frag_size, .new_entry, .new_data, .entry_len, .asm_len_err,
    .pay_valid, .pay_data, .pay_ready, .conn_setup, .cfg_valid, .cfg_data, .cfg_last,
    .hs_mode, .res_frag_en, .ent_frag_en, .cfg_err, .svc_valid, .svc_code, .svc_class,
    .svc_inst, .svc_attr, .svc_wdata, .rsp_valid, .rsp_data, .rsp_err, .sw_in, .evt,
    .cmp_limit, .multi_switch, .sw_out);
  eas_ctrl_model u_eas_ctrl_model (.ref_clk, .asm_ready, .asm_valid, .asm_data, .asm_last,
    .conn_setup, .cfg_valid, .cfg_data, .cfg_last);

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    #2000000;
    bad_count++;
    summarize();
  end
  // random stalls on the drain side keep the buffer edges busy
  always @(posedge ref_clk) pay_ready <= drain_en & 1'($urandom);
  always @(posedge ref_clk) begin
    if (pay_valid === 1'b1 && pay_ready === 1'b1)
      check({1'b0, pay_data}, expq.size() > 0 ? {1'b0, expq.pop_front()} : 9'h100);
    if (new_entry === 1'b1) ne_cnt++;
  end

  function automatic int exp_kept(input int n);
    return n > 255 ? 255 : n;
  endfunction : exp_kept
  function automatic logic exp_tog(input int cnt, input int lim);
    return 1'((cnt / (lim + 1)) % 2);
  endfunction : exp_tog
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  task automatic sv(input logic [7:0] cls, code, ins, attr, wd);
    svc_valid <= 1'b1;
    svc_class <= cls;
    svc_code <= code;
    svc_inst <= ins;
    svc_attr <= attr;
    svc_wdata <= wd;
    @(posedge ref_clk);
    svc_valid <= 1'b0;
    #1;
    check(rsp_valid, 1'b1);
    d = rsp_data;
    e = rsp_err;
    @(posedge ref_clk);
  endtask : sv
  task automatic get(input logic [7:0] ins, attr, input logic x);
    sv(SWIO_CLASS, SVC_GET_SINGLE, ins, attr, 8'h00);
    check({e, d}, {8'h00, x});
  endtask : get
  task automatic set(input logic [7:0] ins, attr, wd);
    sv(SWIO_CLASS, SVC_SET_SINGLE, ins, attr, wd);
    check({e, d}, 9'h000);
    @(posedge ref_clk);
  endtask : set
  task automatic pulse(input int ch, input int cnt);
    repeat (cnt) begin
      evt <= 2'(1 << ch);
      @(posedge ref_clk);
      evt <= 2'b00;
      @(posedge ref_clk);
    end
    repeat (3) @(posedge ref_clk);
  endtask : pulse
  task automatic wait_full;
    int n;
    n = 0;
    while (asm_ready !== 1'b0 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    check(asm_ready, 1'b0);
    if (asm_ready !== 1'b0) summarize();
    repeat (5) @(posedge ref_clk);
    drain_en <= 1'b1;
  endtask : wait_full
  task automatic settle;
    int n;
    n = 0;
    while ((expq.size() > 0 || pay_valid !== 1'b0) && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    check(n < 3000, 1'b1);
    if (n >= 3000) summarize();
  endtask : settle

  initial begin
    void'($urandom(32'h835d));
    rst = 1'b1;
    {svc_valid, svc_code, svc_class, svc_inst, svc_attr, svc_wdata} = '0;
    evt = 2'b00;
    sw_in = 2'b00;
    cmp_limit = 16'h0003;
    multi_switch = 1'b0;
    drain_en = 1'b0;
    exp_out = 2'b00;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    check({hs_mode, res_frag_en, ent_frag_en, asm_ready, pay_valid, sw_out}, 7'b0001000);
    @(posedge ref_clk);
    for (int k = 0; k < 8; k++) begin
      u_eas_ctrl_model.send_cfg('{{7'($urandom), k[0]}, {7'($urandom), k[1]}, {7'($urandom), k[2]}}, 1'b1);
      check({hs_mode, res_frag_en, ent_frag_en, cfg_err}, {k[0], k[1], k[2], 1'b0});
    end
    u_eas_ctrl_model.send_cfg('{8'h00, 8'h00}, 1'b1);
    check({hs_mode, res_frag_en, ent_frag_en, cfg_err}, 4'hf);
    u_eas_ctrl_model.send_cfg('{8'h00, 8'h00, 8'h00}, 1'b1);
    check({hs_mode, res_frag_en, ent_frag_en, cfg_err}, 4'h0);
    u_eas_ctrl_model.send_cfg('{8'h01, 8'h01, 8'h01}, 1'b0);
    check({hs_mode, res_frag_en, ent_frag_en, cfg_err}, 4'h1);
    // first assembly overfills the buffer while the drain side is held off
    prev = 1'b0;
    for (int k = 0; k < 5; k++) begin
      pay = {};
      repeat (k == 0 ? 20 : 1 + $urandom % 40) pay.push_back(8'($urandom));
      foreach (pay[i]) expq.push_back(pay[i]);
      tog = (k == 1 || k == 3) ? prev : 1'($urandom);
      nd = 1'($urandom);
      fn = 8'($urandom);
      ne_before = ne_cnt;
      drain_en <= (k != 0);
      fork
        u_eas_ctrl_model.send_entry(fn, ~fn, 8'(pay.size()), tog, nd, pay, k % 2, ok);
        if (k == 0) wait_full();
      join
      settle();
      check({ok, frag_num, frag_rem, frag_size}, {1'b1, fn, ~fn, 8'(pay.size())});
      check({new_data, entry_len}, {nd, 16'(pay.size())});
      check(ne_cnt - ne_before, 32'(tog != prev));
      prev = tog;
    end
    pay = {};
    for (int i = 0; i < 256; i++) begin
      pay.push_back(8'($urandom));
      if (i < exp_kept(256)) expq.push_back(pay[i]);
    end
    u_eas_ctrl_model.send_entry(8'h11, 8'h00, 8'hff, prev, 1'b1, pay, 0, ok);
    settle();
    check({asm_len_err, entry_len}, {1'b1, 16'h0100});
    u_eas_ctrl_model.send_raw('{8'h5a}, 0, ok);
    repeat (2) @(posedge ref_clk);
    check({asm_len_err, frag_num}, {1'b0, 8'h5a});
    foreach (bad_req[k]) begin
      sv(bad_req[k][39:32], bad_req[k][31:24], bad_req[k][23:16], bad_req[k][15:8], bad_req[k][7:0]);
      check(e, 1'b1);
    end
    check(sw_out, 2'b00);
    for (int k = 0; k < 6; k++) begin
      v = (k >> 1) == 1;
      set(8'(k % 2 + 1), ATTR_DRIVE, {7'h00, v});
      exp_out[k % 2] = v;
      check(sw_out, exp_out);
    end
    repeat (4) begin
      sw_in <= 2'($urandom);
      repeat (3) @(posedge ref_clk);
      get(SWIO_INST_1, ATTR_STATUS, sw_in[0]);
      get(SWIO_INST_2, ATTR_STATUS, sw_in[1]);
    end
    for (int ch = 0; ch < 2; ch++) begin
      inst = 8'(ch + 1);
      multi_switch <= 1'b0;
      pulse(ch, 3);
      get(inst, ATTR_CMP_STATE, 1'b0);
      pulse(ch, 1);
      get(inst, ATTR_CMP_STATE, 1'b1);
      set(inst, ATTR_EV_RESET, 8'h01);
      get(inst, ATTR_CMP_STATE, 1'b0);
      pulse(ch, 4);
      set(inst, ATTR_EV_RESET, 8'h00);
      get(inst, ATTR_CMP_STATE, 1'b1);
      set(inst, ATTR_EV_RESET, 8'h01);
      multi_switch <= 1'b1;
      for (int k = 1; k <= 3; k++) begin
        pulse(ch, 4);
        get(inst, ATTR_CMP_TOGGLE, exp_tog(4 * k, 3));
      end
      set(inst, ATTR_EV_RESET, 8'h00);
      set(inst, ATTR_EV_RESET, 8'h01);
      get(inst, ATTR_CMP_TOGGLE, 1'b0);
    end
    // reset again with every configuration bit and one output set
    u_eas_ctrl_model.send_cfg('{8'h01, 8'h01, 8'h01}, 1'b1);
    set(SWIO_INST_1, ATTR_DRIVE, 8'h01);
    check({hs_mode, res_frag_en, ent_frag_en, sw_out}, 5'b11101);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    check({hs_mode, res_frag_en, ent_frag_en, asm_ready, pay_valid, sw_out}, 7'b0001000);
    check(expq.size(), 0);
    summarize();
  end
endmodule : entry_assembly_and_switch_io_objects_tb_top
